// ==== rtl/ptq_pkg.sv ====
// package: task file map, status layout, opcodes, carriers
package ptq_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 10;
	localparam int STEP_UNIT_US      = 500;
	localparam int STEP_UNIT_CYC     = (STEP_UNIT_US * 1000) / CLK_PERIOD_NS;
	localparam int STEP_PULSE_NS     = 1000;
	localparam int STEP_PULSE_CYC    = (STEP_PULSE_NS + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int MAX_RESTORE_STEPS = 1024;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int CYL_W        = 10;
	localparam int SECTOR_BYTES = 512;
	localparam int NUM_DRIVES   = 4;

	// ----------------------------------------------------------------
	// task file register indices (byte addresses on the port)
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_DATA     = 3'h0;
	localparam logic [2:0] REG_ERROR    = 3'h1; // write: precomp cylinder
	localparam logic [2:0] REG_SEC_CNT  = 3'h2;
	localparam logic [2:0] REG_SEC_NUM  = 3'h3;
	localparam logic [2:0] REG_CYL_LO   = 3'h4;
	localparam logic [2:0] REG_CYL_HI   = 3'h5;
	localparam logic [2:0] REG_SDH      = 3'h6;
	localparam logic [2:0] REG_STAT_CMD = 3'h7; // read status, write command

	// ----------------------------------------------------------------
	// status bits, error bits, size/drive/head fields
	// ----------------------------------------------------------------
	localparam int ST_BUSY  = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEKC = 4;
	localparam int ST_DRQ   = 3;
	localparam int ST_CORR  = 2;
	localparam int ST_ERR   = 0;
	localparam int ERR_TRK0  = 1;
	localparam int ERR_ABORT = 2;
	localparam int SDH_DRV_LO = 3;
	localparam int SDH_HEAD_W = 3;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// command byte layout
	// ----------------------------------------------------------------
	localparam logic [3:0] OPC_RESTORE = 4'h1;
	localparam logic [3:0] OPC_READ    = 4'h2;
	localparam logic [3:0] OPC_SEEK    = 4'h7;
	localparam logic [3:0] OPC_TEST    = 4'h9;
	localparam int CMD_DMA_BIT = 3;

	// controller sequence, gray along the read path
	typedef enum logic [1:0] {
		PTQ_IDLE = 2'b00,
		PTQ_POS  = 2'b01,
		PTQ_DISK = 2'b11,
		PTQ_XFER = 2'b10
	} ptq_state_e;

	// sector fetch request towards the drive side
	typedef struct packed {
		logic [1:0]            drive;
		logic [SDH_HEAD_W-1:0] head;
		logic [CYL_W-1:0]      cyl;
		logic [7:0]            sector;
	} ptq_dsk_req_s;

endpackage

// ==== rtl/ptq_sector_buf.sv ====
// sector buffer: one full sector, disk side fills, host side drains
`timescale 1ns/100ps
`default_nettype none
module ptq_sector_buf #(
	parameter int DW    = 8,
	parameter int DEPTH = 512,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock
	input  wire logic          clk,
	// fill side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	// drain side
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem [DEPTH];

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	// fill from the disk stream
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// host side sees the addressed byte at once
	assign rd_data = mem[rd_addr];

endmodule
`default_nettype wire

// ==== rtl/ptq_stepper.sv ====
// head positioner: steps toward a cylinder or out to track zero
`timescale 1ns/100ps
`default_nettype none
module ptq_stepper
	import ptq_pkg::*;
#(
	parameter int UNIT_CYC = STEP_UNIT_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// request
	input  wire logic             start,
	input  wire logic             home,
	input  wire logic [3:0]       rate,
	input  wire logic [CYL_W-1:0] cur_cyl,
	input  wire logic [CYL_W-1:0] tgt_cyl,
	// drive pins
	input  wire logic             trk0,
	output logic                  step,
	output logic                  dir_in,
	// result
	output logic                  done,
	output logic                  fail,
	output logic [CYL_W-1:0]      pos
);

	logic             run_r;
	logic             home_r;
	logic [10:0]      left_r;
	logic [31:0]      tmr_r;
	logic [31:0]      interval;
	logic [CYL_W-1:0] tgt_r;

	// step interval from the rate code, never shorter than the pulse
	assign interval = (32'(rate) + 32'd1) * 32'(UNIT_CYC)
	                  + 32'(STEP_PULSE_CYC);
	assign step = run_r && (tmr_r > interval - 32'(STEP_PULSE_CYC));

	// ----------------------------------------------------------------
	// stepping sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			run_r  <= 1'b0;
			home_r <= 1'b0;
			left_r <= '0;
			tmr_r  <= '0;
			tgt_r  <= '0;
			dir_in <= 1'b0;
			done   <= 1'b0;
			fail   <= 1'b0;
			pos    <= '0;
		end else begin
			done <= 1'b0;
			if (!run_r) begin
				if (start) begin
					run_r  <= 1'b1;
					home_r <= home;
					fail   <= 1'b0;
					tmr_r  <= '0;
					tgt_r  <= tgt_cyl; // target may not stand after start
					dir_in <= !home && (tgt_cyl > cur_cyl);
					if (home) begin
						left_r <= 11'(MAX_RESTORE_STEPS);
					end else if (tgt_cyl > cur_cyl) begin
						left_r <= 11'(tgt_cyl - cur_cyl);
					end else begin
						left_r <= 11'(cur_cyl - tgt_cyl);
					end
				end
			end else if (tmr_r != '0) begin
				tmr_r <= tmr_r - 32'd1;
			end else if (home_r && trk0) begin
				run_r <= 1'b0; // track zero reached
				done  <= 1'b1;
				pos   <= '0;
			end else if (left_r == '0) begin
				run_r <= 1'b0;
				done  <= 1'b1;
				fail  <= home_r; // no track zero within the limit
				pos   <= home_r ? '0 : tgt_r;
			end else begin
				left_r <= left_r - 11'd1;
				tmr_r  <= interval;
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/ptq_task_file.sv ====
// task file port: registers, command sequencing, sector read-out
`timescale 1ns/100ps
`default_nettype none

// Function
// - parameter registers read back their values, except precomp: address 1 reads the error register
// - positioning commands step heads, no data
// - busy at status bit 7 during operations
// - completion line rises when host needed
// - errors complete exactly like normal completion
// - error flag is status bit 0
// - corrected flag at bit 2, mask 4
// - only read sector moves buffer, implied seek
// - transfer bit places completion before/after buffer
// - all disk data passes full sector buffer
// - read sector byte 0010 D M 00
// - data request held until buffer drained; an accepted command drops it earlier
module ptq_task_file
	import ptq_pkg::*;
#(
	parameter int STEP_UNIT    = STEP_UNIT_CYC,
	parameter int SECTOR_LEN   = SECTOR_BYTES,
	parameter int DRIVES       = NUM_DRIVES
) (
	// clock and reset
	input  wire logic         CLK,
	input  wire logic         RST,
	// task file port
	input  wire logic [2:0]   ADDR,
	input  wire logic [7:0]   WDATA,
	input  wire logic         WR,
	input  wire logic         RD,
	output logic      [7:0]   RDATA,
	// host request lines
	output logic              COMPLETION_REQUEST_LINE,
	output logic              DATA_REQUEST_FLAG,
	// drive positioning
	input  wire logic         TRK0,
	output logic              STEP,
	output logic              STEP_DIR_IN,
	// drive read stream
	output ptq_dsk_req_s      DSK_REQ,
	output logic              DSK_RD_START,
	input  wire logic         DSK_BYTE_VALID,
	input  wire logic [7:0]   DSK_BYTE,
	input  wire logic         DSK_END,
	input  wire logic [7:0]   DSK_ERROR,
	input  wire logic         DSK_CORRECTED
);

	localparam int AW = $clog2(SECTOR_LEN);
	localparam logic [AW-1:0] LAST_BYTE = AW'(SECTOR_LEN - 1);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	ptq_state_e       state_r;
	ptq_state_e       state_nxt;
	logic [7:0]       precomp_r;
	logic [7:0]       sec_cnt_r;
	logic [7:0]       sec_num_r;
	logic [7:0]       cyl_lo_r;
	logic [7:0]       cyl_hi_r;
	logic [7:0]       sdh_r;
	logic [7:0]       cmd_r;
	logic [7:0]       err_reg_r;
	logic [3:0]       rate_r;
	logic             busy_r;
	logic             err_r;
	logic             corr_r;
	logic             seekc_r;
	logic             drq_r;
	logic             irq_r;
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [7:0]       rdata_r;
	logic [7:0]       buf_q;
	logic [CYL_W-1:0] cur_cyl_r [DRIVES];
	logic [1:0]       drv;
	logic [CYL_W-1:0] tgt_cyl;
	logic [7:0]       status;
	logic             cmd_wr;
	logic             cmd_take;
	logic [3:0]       opc;
	logic             opc_pos;
	logic             opc_known;
	logic             stp_start;
	logic             stp_done;
	logic             stp_fail;
	logic [CYL_W-1:0] stp_pos;
	logic             data_rd;
	logic             last_rd;
	logic             irq_set;
	logic             irq_clr;
	logic             fin_pos;
	logic             fin_disk;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	// strobes and command fields
	assign cmd_wr    = WR && (ADDR == REG_STAT_CMD);
	assign cmd_take  = cmd_wr && !busy_r;
	assign opc       = WDATA[7:4];
	assign opc_pos   = (opc == OPC_RESTORE) || (opc == OPC_SEEK)
	                   || (opc == OPC_TEST);
	assign opc_known = opc_pos || (opc == OPC_READ);
	assign drv       = sdh_r[SDH_DRV_LO +: 2];
	assign tgt_cyl   = {cyl_hi_r[CYL_W-9:0], cyl_lo_r};
	assign data_rd   = RD && (ADDR == REG_DATA) && drq_r;
	assign last_rd   = data_rd && (rd_ptr_r == LAST_BYTE);

	// completion events of the two command families
	assign fin_pos   = (state_r == PTQ_POS) && stp_done
	                   && (stp_fail || (cmd_r[7:4] != OPC_READ));
	assign fin_disk  = (state_r == PTQ_DISK) && DSK_END;

	// positioner start: any accepted positioning or read command
	assign stp_start = cmd_take && opc_known;

	// status byte, error and corrected flags at the low end
	always_comb begin
		status           = RESET_BYTE;
		status[ST_BUSY]  = busy_r;
		status[ST_READY] = 1'b1;
		status[ST_SEEKC] = seekc_r;
		status[ST_DRQ]   = drq_r;
		status[ST_CORR]  = corr_r;
		status[ST_ERR]   = err_r;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			PTQ_IDLE, PTQ_XFER: begin
				if (cmd_take && opc_known) begin
					state_nxt = PTQ_POS;
				end else if (cmd_take) begin
					state_nxt = PTQ_IDLE;
				end else if (last_rd) begin
					state_nxt = PTQ_IDLE;
				end
			end
			PTQ_POS: begin
				if (fin_pos) begin
					state_nxt = PTQ_IDLE;
				end else if (stp_done) begin
					state_nxt = PTQ_DISK;
				end
			end
			PTQ_DISK: begin
				if (DSK_END) begin
					state_nxt = PTQ_XFER;
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_r <= PTQ_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// drive read request goes out once the heads are in place
	always_ff @(posedge CLK) begin
		if (RST) begin
			DSK_RD_START <= 1'b0;
		end else begin
			DSK_RD_START <= (state_r == PTQ_POS) && stp_done && !fin_pos;
		end
	end

	// request fields follow the task file
	assign DSK_REQ.drive  = drv;
	assign DSK_REQ.head   = sdh_r[SDH_HEAD_W-1:0];
	assign DSK_REQ.cyl    = tgt_cyl;
	assign DSK_REQ.sector = sec_num_r;

	// ----------------------------------------------------------------
	// task file parameters
	// ----------------------------------------------------------------
	// host writes land while the controller is idle
	always_ff @(posedge CLK) begin
		if (RST) begin
			precomp_r <= RESET_BYTE;
			sec_cnt_r <= RESET_BYTE;
			sec_num_r <= RESET_BYTE;
			cyl_lo_r  <= RESET_BYTE;
			cyl_hi_r  <= RESET_BYTE;
			sdh_r     <= RESET_BYTE;
		end else if (WR && !busy_r) begin
			unique case (ADDR)
				REG_ERROR:   precomp_r <= WDATA;
				REG_SEC_CNT: sec_cnt_r <= WDATA;
				REG_SEC_NUM: sec_num_r <= WDATA;
				REG_CYL_LO:  cyl_lo_r  <= WDATA;
				REG_CYL_HI:  cyl_hi_r  <= WDATA;
				REG_SDH:     sdh_r     <= WDATA;
				default: ;
			endcase
		end
	end

	// command byte and the stepping rate it leaves behind
	always_ff @(posedge CLK) begin
		if (RST) begin
			cmd_r  <= RESET_BYTE;
			rate_r <= '0;
		end else if (cmd_take) begin
			cmd_r <= WDATA;
			if (opc == OPC_RESTORE || opc == OPC_SEEK) begin
				rate_r <= WDATA[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// busy, error and corrected flags
	// ----------------------------------------------------------------
	// every ending, failed or not, goes the same way
	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_r    <= 1'b0;
			err_r     <= 1'b0;
			corr_r    <= 1'b0;
			err_reg_r <= RESET_BYTE;
		end else if (cmd_take) begin
			busy_r    <= opc_known;
			corr_r    <= 1'b0;
			err_r     <= !opc_known;
			err_reg_r <= opc_known ? RESET_BYTE : 8'(1 << ERR_ABORT);
		end else if (fin_pos) begin
			busy_r <= 1'b0;
			if (stp_fail) begin
				err_r     <= 1'b1;
				err_reg_r <= 8'(1 << ERR_TRK0);
			end
		end else if (fin_disk) begin
			busy_r    <= 1'b0;
			err_r     <= |DSK_ERROR;
			err_reg_r <= DSK_ERROR;
			corr_r    <= DSK_CORRECTED;
		end
	end

	// seek complete once the heads settle
	always_ff @(posedge CLK) begin
		if (RST) begin
			seekc_r <= 1'b0;
		end else if (cmd_take && opc_known) begin
			seekc_r <= 1'b0;
		end else if (stp_done) begin
			seekc_r <= !stp_fail;
		end
	end

	// ----------------------------------------------------------------
	// head position per drive
	// ----------------------------------------------------------------
	generate
		for (genvar d = 0; d < DRIVES; d++) begin : g_drv
			always_ff @(posedge CLK) begin
				if (RST) begin
					cur_cyl_r[d] <= '0;
				end else if (stp_done && drv == 2'(d)) begin
					cur_cyl_r[d] <= stp_pos;
				end
			end
		end
	endgenerate

	ptq_stepper #(
		.UNIT_CYC (STEP_UNIT)
	) u_stepper (
		.clk     (CLK),
		.rst     (RST),
		.start   (stp_start),
		.home    (opc == OPC_RESTORE),
		.rate    ((opc == OPC_RESTORE || opc == OPC_SEEK) ?
		          WDATA[3:0] : rate_r),
		.cur_cyl (cur_cyl_r[drv]),
		.tgt_cyl ((opc == OPC_TEST) ? cur_cyl_r[drv] : tgt_cyl),
		.trk0    (TRK0),
		.step    (STEP),
		.dir_in  (STEP_DIR_IN),
		.done    (stp_done),
		.fail    (stp_fail),
		.pos     (stp_pos)
	);

	// ----------------------------------------------------------------
	// sector buffer
	// ----------------------------------------------------------------
	// disk bytes fill it, host reads drain it
	always_ff @(posedge CLK) begin
		if (RST) begin
			wr_ptr_r <= '0;
		end else if (DSK_RD_START) begin
			wr_ptr_r <= '0;
		end else if (state_r == PTQ_DISK && DSK_BYTE_VALID) begin
			wr_ptr_r <= wr_ptr_r + AW'(1);
		end
	end

	ptq_sector_buf #(
		.DW    (8),
		.DEPTH (SECTOR_LEN)
	) u_buf (
		.clk     (CLK),
		.wr_en   (state_r == PTQ_DISK && DSK_BYTE_VALID),
		.wr_addr (wr_ptr_r),
		.wr_data (DSK_BYTE),
		.rd_addr (rd_ptr_r),
		.rd_data (buf_q)
	);

	// host read pointer, one byte per data read, any pace
	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_ptr_r <= '0;
		end else if (fin_disk) begin
			rd_ptr_r <= '0;
		end else if (data_rd) begin
			rd_ptr_r <= rd_ptr_r + AW'(1);
		end
	end

	// data request stands until the last byte is taken or a new command is accepted
	always_ff @(posedge CLK) begin
		if (RST) begin
			drq_r <= 1'b0;
		end else if (fin_disk) begin
			drq_r <= 1'b1;
		end else if (last_rd || cmd_take) begin
			drq_r <= 1'b0;
		end
	end
	assign DATA_REQUEST_FLAG = drq_r;

	// ----------------------------------------------------------------
	// completion request line
	// ----------------------------------------------------------------
	// before the buffer with the transfer bit clear, after it when set
	assign irq_set = fin_pos
	                 || (fin_disk && !cmd_r[CMD_DMA_BIT])
	                 || (last_rd && cmd_r[CMD_DMA_BIT])
	                 || (cmd_take && !opc_known);
	assign irq_clr = (RD && ADDR == REG_STAT_CMD) || cmd_wr;

	// low to high on each request, dropped on status read or command write; set wins
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_set || (irq_r && !irq_clr);
		end
	end
	assign COMPLETION_REQUEST_LINE = irq_r;

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// parameters read back so failures can be located
	always_ff @(posedge CLK) begin
		if (RST) begin
			rdata_r <= RESET_BYTE;
		end else if (RD) begin
			unique case (ADDR)
				REG_DATA:     rdata_r <= buf_q;
				REG_ERROR:    rdata_r <= err_reg_r;
				REG_SEC_CNT:  rdata_r <= sec_cnt_r;
				REG_SEC_NUM:  rdata_r <= sec_num_r;
				REG_CYL_LO:   rdata_r <= cyl_lo_r;
				REG_CYL_HI:   rdata_r <= cyl_hi_r;
				REG_SDH:      rdata_r <= sdh_r;
				REG_STAT_CMD: rdata_r <= status;
			endcase
		end else begin
			rdata_r <= RESET_BYTE;
		end
	end
	assign RDATA = rdata_r;

endmodule
`default_nettype wire

// ==== tb/ptq_drive_model.sv ====
// drive model: head position, track zero and sector byte stream
`timescale 1ns/100ps
`default_nettype none
module ptq_drive_model #(
	parameter int LEN = 16
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// pace and outcome controls
	input  wire logic [3:0] gap,
	input  wire logic [7:0] err_code,
	input  wire logic       corr,
	// positioning
	input  wire logic       step,
	input  wire logic       dir_in,
	output logic            trk0,
	output logic      [9:0] cyl,
	// read stream
	input  wire logic       rd_start,
	output logic            byte_valid,
	output logic      [7:0] byte_data,
	output logic            sec_end,
	output logic      [7:0] sec_err,
	output logic            sec_corr
);
	logic step_q;

	// heads start off track zero, one cylinder per step rising edge
	always @(posedge clk) begin
		step_q <= step;
		if (rst)
			cyl <= 10'h003;
		else if (step && !step_q)
			cyl <= dir_in ? cyl + 10'h001 : cyl - 10'h001;
	end
	assign trk0 = (cyl == 10'h000);

	// stream one sector; lines scramble when not valid
	initial begin
		byte_valid = 1'b0;
		byte_data = 8'h00;
		sec_end = 1'b0;
		sec_err = 8'h00;
		sec_corr = 1'b0;
		forever begin
			@(posedge clk);
			if (rd_start && !rst) begin
				repeat (3) @(posedge clk);
				for (int i = 0; i < LEN; i++) begin
					byte_valid <= 1'b1;
					byte_data <= 8'(i * 7 + 1);
					@(posedge clk);
					byte_valid <= 1'b0;
					byte_data <= ~byte_data;
					repeat (gap) @(posedge clk);
				end
				sec_end <= 1'b1;
				sec_err <= err_code;
				sec_corr <= corr;
				@(posedge clk);
				sec_end <= 1'b0;
				sec_err <= ~err_code;
				sec_corr <= ~corr;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/ptq_task_file_checker.sv ====
// checker: timing relations at the task file port
`timescale 1ns/100ps
`default_nettype none
module ptq_task_file_checker
	import ptq_pkg::*;
#(
	parameter int SECTOR_LEN = SECTOR_BYTES
) (
	// clock and reset
	input wire logic       CLK,
	input wire logic       RST,
	// register port
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	// request lines and drive side
	input wire logic       COMPLETION_REQUEST_LINE,
	input wire logic       DATA_REQUEST_FLAG,
	input wire logic       STEP,
	input wire logic       DSK_RD_START,
	input wire logic       DSK_END
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	logic        dma_r;
	logic [15:0] rd_cnt_r;
	logic [7:0]  stp_cnt_r;

	// transfer mode of the last command
	always_ff @(posedge CLK) begin
		if (RST)
			dma_r <= 1'b0;
		else if (WR && ADDR == REG_STAT_CMD)
			dma_r <= WDATA[CMD_DMA_BIT];
	end
	// sector bytes taken by the host
	always_ff @(posedge CLK) begin
		if (RST || DSK_END)
			rd_cnt_r <= 16'h0000;
		else if (RD && ADDR == REG_DATA && DATA_REQUEST_FLAG)
			rd_cnt_r <= rd_cnt_r + 16'h0001;
	end
	// width of the current step pulse
	always_ff @(posedge CLK) begin
		if (!STEP)
			stp_cnt_r <= 8'h00;
		else
			stp_cnt_r <= stp_cnt_r + 8'h01;
	end

	sequence s_data_rd;
		RD && ADDR == REG_DATA && DATA_REQUEST_FLAG;
	endsequence
	sequence s_last_rd;
		s_data_rd ##0 rd_cnt_r == SECTOR_LEN - 1;
	endsequence

	property p_rdata_idle;
		!RD |=> RDATA == 8'h00;
	endproperty
	property p_pio_line;
		DSK_END && !dma_r |=> COMPLETION_REQUEST_LINE;
	endproperty
	property p_dma_quiet;
		DSK_END && dma_r |=> !COMPLETION_REQUEST_LINE;
	endproperty
	property p_dma_line;
		s_last_rd ##0 dma_r |=> COMPLETION_REQUEST_LINE;
	endproperty
	property p_end_flag;
		DSK_END |=> DATA_REQUEST_FLAG;
	endproperty
	property p_flag_hold;
		s_data_rd ##0 rd_cnt_r < SECTOR_LEN - 1 |=> DATA_REQUEST_FLAG;
	endproperty
	property p_flag_drop;
		s_last_rd |=> !DATA_REQUEST_FLAG;
	endproperty
	property p_line_drop;
		COMPLETION_REQUEST_LINE && RD && ADDR == REG_STAT_CMD && !DSK_END
			|=> !COMPLETION_REQUEST_LINE;
	endproperty
	property p_start_pulse;
		DSK_RD_START |=> !DSK_RD_START;
	endproperty
	property p_step_width;
		$fell(STEP) |-> stp_cnt_r == STEP_PULSE_CYC;
	endproperty

	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read");
	a_pio_line: assert property (p_pio_line)
		else $error("line not raised with sector end");
	a_dma_quiet: assert property (p_dma_quiet)
		else $error("line raised before transfer");
	a_dma_line: assert property (p_dma_line)
		else $error("line not raised after last byte");
	a_end_flag: assert property (p_end_flag)
		else $error("data flag not set at sector end");
	a_flag_hold: assert property (p_flag_hold)
		else $error("data flag dropped early");
	a_flag_drop: assert property (p_flag_drop)
		else $error("data flag stuck after last byte");
	a_line_drop: assert property (p_line_drop)
		else $error("line not dropped on status read");
	a_start_pulse: assert property (p_start_pulse)
		else $error("read start longer than one cycle");
	a_step_width: assert property (p_step_width)
		else $error("step pulse width wrong");
endmodule

bind ptq_task_file ptq_task_file_checker #(.SECTOR_LEN(SECTOR_LEN)) u_chk (
	.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .COMPLETION_REQUEST_LINE(COMPLETION_REQUEST_LINE),
	.DATA_REQUEST_FLAG(DATA_REQUEST_FLAG), .STEP(STEP),
	.DSK_RD_START(DSK_RD_START), .DSK_END(DSK_END)
);
`default_nettype wire

// ==== tb/ptq_task_file_tb.sv ====
// testbench: host side sequences against the task file port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module ptq_task_file_tb;
	import ptq_pkg::*;
	localparam int LEN = 16;
	logic clk, rst, wr_s, rd_s, line, flag, trk0, step, dir_in, rd_start;
	logic bv, dend, dcorr, corr;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, bdat, derr, err;
	logic [3:0] gap;
	logic [9:0] cyl;
	ptq_dsk_req_s dsk_req;
	int error_cnt, n_checks, cyc;

	ptq_task_file #(.STEP_UNIT(10), .SECTOR_LEN(LEN), .DRIVES(4)) uut (
		.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .COMPLETION_REQUEST_LINE(line),
		.DATA_REQUEST_FLAG(flag), .TRK0(trk0), .STEP(step),
		.STEP_DIR_IN(dir_in), .DSK_REQ(dsk_req), .DSK_RD_START(rd_start),
		.DSK_BYTE_VALID(bv), .DSK_BYTE(bdat), .DSK_END(dend),
		.DSK_ERROR(derr), .DSK_CORRECTED(dcorr));
	ptq_drive_model #(.LEN(LEN)) u_drv (
		.clk(clk), .rst(rst), .gap(gap), .err_code(err), .corr(corr),
		.step(step), .dir_in(dir_in), .trk0(trk0), .cyl(cyl),
		.rd_start(rd_start), .byte_valid(bv), .byte_data(bdat),
		.sec_end(dend), .sec_err(derr), .sec_corr(dcorr));

	// ----------------------------------------------------------------
	// bus cycles and helpers
	// ----------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_line();
		for (int i = 0; i < 4000 && line !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(line, 1'b1)
	endtask
	task automatic rd_block(input int pace);
		logic [7:0] d;
		for (int i = 0; i < LEN; i++) begin
			repeat (i % pace) @(posedge clk);
			rd(REG_DATA, d);
			`CHK(d, 8'(i * 7 + 1))
		end
		`CHK(flag, 1'b0)
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [7:0] d;
		rd(REG_STAT_CMD, d);
		`CHK(d, 8'h40)
		wr(REG_SEC_NUM, 8'h05);
		wr(REG_SDH, 8'h0A);
		wr(REG_CYL_LO, 8'h02);
		wr(REG_CYL_HI, 8'h00);
		rd(REG_SDH, d);
		`CHK(d, 8'h0A)
		rd(REG_CYL_LO, d);
		`CHK(d, 8'h02)
		`CHK(dsk_req, ptq_dsk_req_s'{2'h1, 3'h2, 10'h2, 8'h5})
	endtask
	task automatic t_position(input logic [7:0] cmd, input logic [9:0] c);
		logic [7:0] d;
		wr(REG_STAT_CMD, cmd);
		rd(REG_STAT_CMD, d);
		`CHK(d[ST_BUSY], 1'b1)
		wr(REG_SEC_NUM, 8'hEE);
		wait_line();
		rd(REG_STAT_CMD, d);
		`CHK(d & 8'h89, 8'h00)
		`CHK(line, 1'b0)
		`CHK(cyl, c)
		rd(REG_SEC_NUM, d);
		`CHK(d, 8'h05)
	endtask
	task automatic t_read_pio();
		logic [7:0] d;
		gap <= 4'h1;
		wr(REG_STAT_CMD, 8'h20);
		wait_line();
		rd(REG_STAT_CMD, d);
		`CHK(d & 8'h8D, 8'h08)
		`CHK(flag, 1'b1)
		rd_block(3);
		`CHK(line, 1'b0)
	endtask
	task automatic t_read_dma_err();
		logic [7:0] d;
		gap <= 4'h3;
		err <= 8'h40;
		corr <= 1'b1;
		wr(REG_STAT_CMD, 8'h28);
		d = 8'hFF;
		for (int i = 0; i < 400 && d[ST_BUSY] !== 1'b0; i++)
			rd(REG_STAT_CMD, d);
		`CHK(d & 8'h8D, 8'h0D)
		`CHK(line, 1'b0)
		rd(REG_ERROR, d);
		`CHK(d, 8'h40)
		rd_block(1);
		`CHK(line, 1'b1)
	endtask
	task automatic t_abort();
		logic [7:0] d;
		rd(REG_STAT_CMD, d);
		`CHK(line, 1'b0)
		wr(REG_STAT_CMD, {OPC_TEST, 4'h0});
		wait_line();
		rd(REG_STAT_CMD, d);
		`CHK(d & 8'h91, 8'h10)
		`CHK(cyl, 10'h002)
		wr(REG_STAT_CMD, 8'hF0);
		wait_line();
		rd(REG_STAT_CMD, d);
		`CHK(d & 8'h81, 8'h01)
		rd(REG_ERROR, d);
		`CHK(d[ERR_ABORT], 1'b1)
	endtask

	// ----------------------------------------------------------------
	// clock, timeout, main sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		rst = 1'b1;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		gap = 4'h1;
		err = 8'h00;
		corr = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_position({OPC_RESTORE, 4'h0}, 10'h000);
		t_position({OPC_SEEK, 4'h1}, 10'h002);
		t_read_pio();
		t_read_dma_err();
		t_abort();
		stop_test();
	end
endmodule
`default_nettype wire
